// >>> rtcal_pkg.sv
/*
 * Shared constants and types of the RTC alarm and load-capacitance stepping block:
 * register offsets, field positions, reset values and the stepping states.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
`default_nettype none

package rtcal_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   typedef logic [ADDR_W-1:0] rtcal_addr_t;
   typedef logic [DATA_W-1:0] rtcal_data_t;
   typedef logic [DATA_W/8-1:0] rtcal_strb_t;
   typedef logic [1:0] rtcal_resp_t;

   // Register byte offsets
   localparam rtcal_addr_t ADDR_CTRL = 8'h00;
   localparam rtcal_addr_t ADDR_MATCH = 8'h04;
   localparam rtcal_addr_t ADDR_TIMER = 8'h08;
   localparam rtcal_addr_t ADDR_STATE = 8'h0c;
   localparam rtcal_addr_t ADDR_IRQ_STS = 8'h10;
   localparam rtcal_addr_t ADDR_IRQ_CLR = 8'h14;
   localparam rtcal_addr_t ADDR_IRQ_EN = 8'h18;

   // Control register fields
   localparam int CTRL_W = 12;
   localparam int CTRL_AEN = 0;
   localparam int CTRL_AUTO = 1;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_STEP = 3;
   localparam int CTRL_RST_RT = 4;
   localparam int CTRL_WAKE_RT = 5;
   localparam int CTRL_CAP_LSB = 8;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h004;

   // Load-capacitance code
   localparam int CAP_W = 4;
   localparam logic [CAP_W-1:0] CAP_MIN = 4'h0;
   localparam int STEP_CYCLES_DEF = 1024;

   // State register fields
   localparam int ST_REACHED = 4;
   localparam int ST_FLAG = 5;

   // Interrupt status, clear and enable layout
   localparam int IRQ_W = 2;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_REACHED = 1;

   // Reset values
   localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
   localparam logic [31:0] MATCH_RESET = 32'hffff_ffff;

   // Bus responses
   localparam rtcal_resp_t RESP_OKAY = 2'h0;
   localparam rtcal_resp_t RESP_SLVERR = 2'h2;

   // Load-capacitance stepping states
   typedef enum logic [1:0] {
      STEP_IDLE,
      STEP_RAMP,
      STEP_DONE
   } rtcal_step_t;

endpackage

`default_nettype wire

// >>> rtcal_top.sv
/*
 * RTC alarm compare with auto-reset and routing, plus automatic stepping of the
 * crystal load-capacitance code, behind an AXI4-Lite register slave.
 * Assumes clk_i is the RTC clock, inputs are synchronous to it, and ce_i gates all state.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcal_top #(
   parameter int STEP_CYCLES = rtcal_pkg::STEP_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire rtcal_pkg::rtcal_addr_t s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire rtcal_pkg::rtcal_data_t s_axi_wdata_i,
   input wire rtcal_pkg::rtcal_strb_t s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output rtcal_pkg::rtcal_resp_t s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire rtcal_pkg::rtcal_addr_t s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output rtcal_pkg::rtcal_data_t s_axi_rdata_o,
   output rtcal_pkg::rtcal_resp_t s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic alarm_event_flag_o,
   output logic mcu_reset_req_o,
   output logic wake_req_o,
   output logic irq_o,
   output logic [rtcal_pkg::CAP_W-1:0] load_cap_setting_o,
   output logic load_cap_reached_o
);
   import rtcal_pkg::*;

   localparam int CNT_W = $clog2(STEP_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);

   // Refuse a stepping interval the counter cannot serve
   if (STEP_CYCLES < 1) begin : g_chk
      $error("STEP_CYCLES must be at least 1");
   end

   // Byte-lane merge of a write into a stored word
   function automatic rtcal_data_t wmerge(input rtcal_data_t old_v, input rtcal_data_t new_v,
                                          input rtcal_strb_t strb);
      rtcal_data_t res;
      res = old_v;
      for (int i = 0; i < DATA_W / 8; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   rtcal_addr_t awaddr_r;
   rtcal_data_t wdata_r, rdata_r;
   rtcal_strb_t wstrb_r;
   rtcal_resp_t bresp_r, rresp_r;
   logic [CTRL_W-1:0] ctrl_r, ctrl_new;
   logic [31:0] match_r, timer_r;
   logic [IRQ_W-1:0] irq_sts_r, irq_en_r, irq_set;
   logic flag_r, rst_req_r, wake_req_r, irq_r, reached_r, alarm_hit;
   logic [CAP_W-1:0] applied_r, target;
   logic [CNT_W-1:0] step_cnt_r;
   rtcal_step_t step_r;
   logic wr_go, wr_ctrl, wr_match, wr_timer, wr_clr, wr_en, wr_map;

   // Write decode, taken once both address and data are held
   assign wr_go = aw_got_r & w_got_r & ~bvalid_r;
   assign wr_ctrl = wr_go & (awaddr_r == ADDR_CTRL);
   assign wr_match = wr_go & (awaddr_r == ADDR_MATCH);
   assign wr_timer = wr_go & (awaddr_r == ADDR_TIMER);
   assign wr_clr = wr_go & (awaddr_r == ADDR_IRQ_CLR);
   assign wr_en = wr_go & (awaddr_r == ADDR_IRQ_EN);
   assign wr_map = (awaddr_r == ADDR_CTRL) | (awaddr_r == ADDR_MATCH) |
                   (awaddr_r == ADDR_TIMER) | (awaddr_r == ADDR_IRQ_CLR) |
                   (awaddr_r == ADDR_IRQ_EN) | (awaddr_r == ADDR_STATE) |
                   (awaddr_r == ADDR_IRQ_STS);
   assign ctrl_new = CTRL_W'(wmerge(32'(ctrl_r), wdata_r, wstrb_r));
   assign target = ctrl_r[CTRL_CAP_LSB +: CAP_W]; // 4-bit code, 16 settings

   // Write channels: address and data taken in either order, response follows both
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && awready_r) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && wready_r) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR; // Read-only targets answer OKAY
         end else if (bvalid_r && s_axi_bready_i) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Read channel: data registered on the same edge that takes the address
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid_i && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr_i)
               ADDR_CTRL: rdata_r <= 32'(ctrl_r);
               ADDR_MATCH: rdata_r <= match_r;
               ADDR_TIMER: rdata_r <= timer_r;
               ADDR_STATE: rdata_r <= 32'({flag_r, reached_r, applied_r});
               ADDR_IRQ_STS: rdata_r <= 32'(irq_sts_r);
               ADDR_IRQ_EN: rdata_r <= 32'(irq_en_r);
               ADDR_IRQ_CLR: rdata_r <= '0;
               default: begin
                  rdata_r <= '0;
                  rresp_r <= RESP_SLVERR;
               end
            endcase
         end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // Software-written configuration: control, match value, interrupt enables
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ctrl_r <= CTRL_RESET;
         match_r <= MATCH_RESET;
         irq_en_r <= '0;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_new;
         end
         if (wr_match) begin
            match_r <= wmerge(match_r, wdata_r, wstrb_r);
         end
         if (wr_en) begin
            irq_en_r <= wdata_r[IRQ_W-1:0];
         end
      end
   end

   // Exact 32-bit equality with the match value, only on a counting cycle
   assign alarm_hit = ctrl_r[CTRL_AEN] & ctrl_r[CTRL_RUN] & (timer_r == match_r);

   // Timer: +1 per cycle while CTRL_RUN is set, wraps, cleared after an auto-reset alarm
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         timer_r <= TIMER_RESET;
      end else if (ce_i) begin
         if (wr_timer) begin
            timer_r <= wmerge(timer_r, wdata_r, wstrb_r);
         end else if (ctrl_r[CTRL_RUN]) begin
            if (flag_r && ctrl_r[CTRL_AUTO]) begin
               timer_r <= '0;
            end else begin
               timer_r <= timer_r + 32'h1;
            end
         end
      end
   end

   // One-cycle alarm flag, dropped at once when the enable is cleared
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         flag_r <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl && !ctrl_new[CTRL_AEN]) begin
            flag_r <= 1'b0;
         end else begin
            flag_r <= alarm_hit & ~flag_r; // Never two cycles in a row
         end
      end
   end

   // Routing of the alarm event to reset and wake-up requests
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rst_req_r <= 1'b0;
         wake_req_r <= 1'b0;
      end else if (ce_i) begin
         rst_req_r <= flag_r & ctrl_r[CTRL_RST_RT];
         wake_req_r <= flag_r & ctrl_r[CTRL_WAKE_RT];
      end
   end

   // Sticky interrupt status; a new event wins over a clear in the same cycle
   assign irq_set = {load_cap_hit_rise(applied_r, target, reached_r), flag_r};

   function automatic logic load_cap_hit_rise(input logic [CAP_W-1:0] a,
                                              input logic [CAP_W-1:0] t, input logic r);
      return (a == t) & ~r;
   endfunction

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_sts_r <= '0;
         irq_r <= 1'b0;
      end else if (ce_i) begin
         irq_sts_r <= (irq_sts_r & ~(wr_clr ? wdata_r[IRQ_W-1:0] : '0)) | irq_set;
         irq_r <= |(irq_sts_r & irq_en_r);
      end
   end

   // Load-capacitance stepping: ramp from the smallest code up to the programmed one
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         step_r <= STEP_IDLE;
         applied_r <= CAP_MIN;
         step_cnt_r <= '0;
      end else if (ce_i) begin
         case (step_r)
            STEP_IDLE: begin
               step_cnt_r <= '0;
               if (ctrl_r[CTRL_STEP]) begin
                  applied_r <= CAP_MIN;
                  step_r <= STEP_RAMP;
               end else begin
                  applied_r <= target;
               end
            end
            STEP_RAMP: begin
               if (!ctrl_r[CTRL_STEP]) begin
                  step_r <= STEP_IDLE;
               end else if (applied_r == target) begin
                  step_r <= STEP_DONE;
               end else if (applied_r > target) begin
                  applied_r <= CAP_MIN;
                  step_cnt_r <= '0;
               end else if (step_cnt_r == CNT_LAST) begin
                  applied_r <= applied_r + 4'h1;
                  step_cnt_r <= '0;
               end else begin
                  step_cnt_r <= step_cnt_r + CNT_W'(1);
               end
            end
            STEP_DONE: begin
               step_cnt_r <= '0;
               if (!ctrl_r[CTRL_STEP]) begin
                  step_r <= STEP_IDLE;
               end else if (applied_r != target) begin
                  step_r <= STEP_RAMP;
               end
            end
            default: step_r <= STEP_IDLE;
         endcase
      end
   end

   // Reached flag follows the comparison of applied and programmed codes
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         reached_r <= 1'b0;
      end else if (ce_i) begin
         reached_r <= (applied_r == target);
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign alarm_event_flag_o = flag_r;
   assign mcu_reset_req_o = rst_req_r;
   assign wake_req_o = wake_req_r;
   assign irq_o = irq_r;
   assign load_cap_setting_o = applied_r;
   assign load_cap_reached_o = reached_r;

   // Checks of alarm and stepping behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   alarm_match_a: assert property (ce_i && alarm_hit && !flag_r && !wr_ctrl |=> flag_r)
      else $error("alarm flag missing after exact match");
   alarm_pulse_a: assert property (ce_i && flag_r |=> !flag_r)
      else $error("alarm flag held longer than one cycle");
   flag_gated_a: assert property (!ctrl_r[CTRL_AEN] |-> !flag_r)
      else $error("alarm flag set while alarm disabled");
   auto_clear_a: assert property (ce_i && flag_r && ctrl_r[CTRL_AUTO]
                                  && ctrl_r[CTRL_RUN] && !wr_timer |=> timer_r == 32'h0)
      else $error("timer not cleared after auto-reset alarm");
   timer_step_a: assert property (rstn_i && ce_i && ctrl_r[CTRL_RUN] && !wr_timer
                                  && !(flag_r && ctrl_r[CTRL_AUTO])
                                  |=> timer_r == $past(timer_r) + 32'h1)
      else $error("timer did not advance by one");
   timer_wrap_a: assert property (ce_i && ctrl_r[CTRL_RUN] && !wr_timer
                                  && !ctrl_r[CTRL_AUTO] && timer_r == 32'hffff_ffff
                                  |=> timer_r == 32'h0)
      else $error("timer did not wrap to zero");
   route_req_a: assert property (ce_i && flag_r && ctrl_r[CTRL_RST_RT]
                                 && ctrl_r[CTRL_WAKE_RT]
                                 |=> mcu_reset_req_o && wake_req_o && irq_sts_r[IRQ_ALARM])
      else $error("alarm event not routed");
   step_up_a: assert property (ce_i && step_r == STEP_RAMP && ctrl_r[CTRL_STEP]
                               && applied_r < target && !wr_ctrl
                               |=> applied_r == $past(applied_r)
                                   || applied_r == $past(applied_r) + 4'h1)
      else $error("applied code jumped by more than one step");
   step_start_a: assert property (ce_i && step_r == STEP_IDLE && ctrl_r[CTRL_STEP]
                                  |=> applied_r == CAP_MIN)
      else $error("ramp did not start from smallest code");
   reached_a: assert property (rstn_i && ce_i
                               |=> reached_r == $past(applied_r == target))
      else $error("reached flag disagrees with codes");

   alarm_auto_c: cover property (flag_r && ctrl_r[CTRL_AUTO] ##2 timer_r == 32'h1);
   alarm_wake_c: cover property (flag_r ##1 wake_req_o);
   ramp_done_c: cover property (step_r == STEP_RAMP ##1 step_r == STEP_DONE && reached_r);
   irq_raise_c: cover property (!irq_o ##1 irq_o);

endmodule // rtcal_top

`default_nettype wire

// >>> rtcal_testbench.sv
/* Self-checking bench of the RTC alarm and load-cap stepping block.
   Assumes rtcal_pkg and rtcal_top are compiled before it. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import rtcal_pkg::*;
   localparam int STEPS = 2;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ce = 1'b1;
   rtcal_addr_t aw_addr = '0;
   rtcal_addr_t ar_addr = '0;
   rtcal_data_t w_data = '0;
   logic aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, flag, flag_q, rst_req, wake, irq, reached;
   rtcal_resp_t b_resp, r_resp, resp;
   rtcal_data_t r_data, rd, rd2;
   logic [CAP_W-1:0] cap;
   int error_cnt = 0;
   int comparisons = 0;
   int n;

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   rtcal_top #(.STEP_CYCLES(STEPS)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
      .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_vld), .s_axi_awready_o(aw_rdy),
      .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_vld),
      .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld),
      .s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_vld),
      .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
      .s_axi_rvalid_o(r_vld), .s_axi_rready_i(r_rdy), .alarm_event_flag_o(flag),
      .mcu_reset_req_o(rst_req), .wake_req_o(wake), .irq_o(irq),
      .load_cap_setting_o(cap), .load_cap_reached_o(reached)
   );

   // Compare one value and count it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Bus write: both channels offered together, each dropped once taken
   task automatic wr(input rtcal_addr_t a, input rtcal_data_t d, output rtcal_resp_t r);
      int k;
      k = 0;
      @(posedge clk_i);
      aw_addr <= a;
      w_data <= d;
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      b_rdy <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
         if (aw_rdy) aw_vld <= 1'b0;
         if (w_rdy) w_vld <= 1'b0;
      end while (b_vld !== 1'b1 && k < 100);
      r = b_resp;
      b_rdy <= 1'b0;
      chk(k < 100, 1, "write answer");
   endtask

   // Bus read
   task automatic rdr(input rtcal_addr_t a, output rtcal_data_t d, output rtcal_resp_t r);
      int k;
      k = 0;
      @(posedge clk_i);
      ar_addr <= a;
      ar_vld <= 1'b1;
      r_rdy <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
         if (ar_rdy) ar_vld <= 1'b0;
      end while (r_vld !== 1'b1 && k < 100);
      d = r_data;
      r = r_resp;
      r_rdy <= 1'b0;
      chk(k < 100, 1, "read answer");
   endtask

   // Count edges until the alarm flag is seen, up to a limit
   task automatic wait_flag(input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (flag !== 1'b1 && k < lim);
   endtask

   // Alarm flag never stands two cycles in a row
   always @(posedge clk_i) begin
      if (rstn_i && flag === 1'b1 && flag_q === 1'b1) chk(0, 1, "flag too long");
      flag_q <= flag;
   end

   // Reset values, read-only places, unmapped address, running timer
   task automatic t_regs;
      rdr(ADDR_CTRL, rd, resp);
      chk(rd, {20'h0, CTRL_RESET}, "ctrl reset");
      rdr(ADDR_MATCH, rd, resp);
      chk(rd, MATCH_RESET, "match reset");
      rdr(ADDR_IRQ_EN, rd, resp);
      chk(rd, 32'h0, "irq enable reset");
      rdr(ADDR_STATE, rd, resp);
      chk(rd, 32'h10, "state reset");
      wr(8'h1c, 32'hffff_ffff, resp);
      chk(resp, RESP_SLVERR, "unmapped write");
      rdr(8'h1c, rd, resp);
      chk(rd, 32'h0, "unmapped read");
      chk(resp, RESP_SLVERR, "unmapped read resp");
      wr(ADDR_STATE, 32'hffff_ffff, resp);
      chk(resp, RESP_OKAY, "state write resp");
      rdr(ADDR_STATE, rd, resp);
      chk(rd, 32'h10, "state unchanged");
      rdr(ADDR_IRQ_CLR, rd, resp);
      chk(rd, 32'h0, "clear reads zero");
      rdr(ADDR_TIMER, rd, resp);
      rdr(ADDR_TIMER, rd2, resp);
      chk((rd2 - rd) > 0 && (rd2 - rd) < 20, 1, "timer advance");
      $display("register test done");
   endtask

   // Alarm with reset and wake routing, interrupt raised and cleared
   task automatic t_alarm;
      wr(ADDR_CTRL, 32'h0, resp);
      wr(ADDR_TIMER, 32'h1000, resp);
      wr(ADDR_MATCH, 32'h1010, resp);
      wr(ADDR_IRQ_CLR, 32'h3, resp);
      wr(ADDR_IRQ_EN, 32'h1, resp);
      wr(ADDR_CTRL, 32'h35, resp);
      wait_flag(40, n);
      chk(n >= 12 && n <= 18, 1, "alarm moment");
      @(posedge clk_i);
      chk(flag, 1'b0, "flag one cycle");
      chk({rst_req, wake}, 2'b11, "reset and wake routes");
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1, "interrupt route");
      rdr(ADDR_IRQ_STS, rd, resp);
      chk(rd[IRQ_ALARM], 1'b1, "alarm status");
      wr(ADDR_IRQ_CLR, 32'h1, resp);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0, "interrupt cleared");
      $display("alarm test done");
   endtask

   // Auto-reset gives a fixed period; masked status keeps the line low
   task automatic t_auto;
      wr(ADDR_CTRL, 32'h0, resp);
      wr(ADDR_IRQ_EN, 32'h0, resp);
      wr(ADDR_TIMER, 32'h20, resp);
      wr(ADDR_MATCH, 32'h28, resp);
      wr(ADDR_CTRL, 32'h7, resp);
      wait_flag(80, n);
      chk(n < 80, 1, "first auto alarm");
      wait_flag(100, n);
      chk(n, 42, "auto-reset period");
      chk(irq, 1'b0, "masked interrupt");
      rdr(ADDR_IRQ_STS, rd, resp);
      chk(rd[IRQ_ALARM], 1'b1, "sticky status");
      $display("auto-reset test done");
   endtask

   // Timer wraps past its maximum; only the full word matches
   task automatic t_wrap;
      wr(ADDR_CTRL, 32'h0, resp);
      wr(ADDR_TIMER, 32'hffff_fff0, resp);
      wr(ADDR_MATCH, 32'h0000_0004, resp);
      wr(ADDR_CTRL, 32'h5, resp);
      wait_flag(60, n);
      chk(n >= 17 && n <= 23, 1, "alarm after wrap");
      $display("wrap test done");
   endtask

   // Stepping from code 0 up through every code to 15
   task automatic t_step;
      int prev;
      int k;
      wr(ADDR_CTRL, 32'h304, resp);
      repeat (3) @(posedge clk_i);
      chk({cap, reached}, {4'h3, 1'b1}, "direct code");
      wr(ADDR_IRQ_CLR, 32'h2, resp); // Reached status must come back from the ramp alone
      wr(ADDR_CTRL, 32'hf0c, resp);
      k = 0;
      while (cap !== 4'h0 && k < 6) begin
         @(posedge clk_i);
         k++;
      end
      chk(cap, 4'h0, "ramp starts smallest");
      prev = 0;
      k = 0;
      while (prev != 15 && k < 80) begin
         @(posedge clk_i);
         k++;
         if (cap !== prev[3:0]) begin
            chk(cap, prev[3:0] + 4'h1, "one step up");
            prev = int'(cap);
         end
         if (prev != 15) chk(reached, 1'b0, "reached while short");
      end
      chk(k >= 15 * STEPS - 1 && k <= 15 * STEPS + 1, 1, "step interval");
      repeat (2) @(posedge clk_i);
      chk({cap, reached}, {4'hf, 1'b1}, "reached final");
      rdr(ADDR_IRQ_STS, rd, resp);
      chk(rd[IRQ_REACHED], 1'b1, "reached status");
      $display("stepping test done");
   endtask

   // Clock enable low for ten edges freezes the running timer
   task automatic t_hold;
      rdr(ADDR_TIMER, rd, resp);
      @(posedge clk_i);
      ce <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce <= 1'b1;
      rdr(ADDR_TIMER, rd2, resp);
      chk((rd2 - rd) > 0 && (rd2 - rd) < 10, 1, "timer frozen");
      $display("clock enable test done");
   endtask

   // Verdict and end of run
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_regs;
      t_hold;
      t_alarm;
      t_auto;
      t_wrap;
      t_step;
      test_done;
   end

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #1_000_000;
      error_cnt++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done;
   end
endmodule // testbench

`default_nettype wire
